// File: src/lds_pkg.sv
package lds_pkg;
   // ******************************
   // Register word indices
   // ******************************
   localparam logic [7:0] LDS_IDX_MODE_EN = 8'h01;
   localparam logic [7:0] LDS_IDX_SENSE_CTRL = 8'h20;
   localparam logic [7:0] LDS_IDX_GPIO_ROUTE = 8'h21;
   localparam logic [7:0] LDS_IDX_STATUS = 8'h27;
   localparam logic [7:0] LDS_IDX_IRQ_STAT = 8'h30;
   localparam logic [7:0] LDS_IDX_IRQ_CLR = 8'h31;
   localparam logic [7:0] LDS_IDX_IRQ_EN = 8'h32;

   // ******************************
   // Field positions
   // ******************************
   localparam int LDS_BIT_STB_WAKE = 8;
   localparam int LDS_BIT_SLP_WAKE = 10;
   localparam int LDS_BIT_SHORT_SEL = 0;
   localparam int LDS_BIT_POWER_ON = 3;
   localparam int LDS_BIT_ROUTE_DET = 0;
   localparam int LDS_BIT_ROUTE_REL = 1;
   localparam int LDS_BIT_PRESENT = 15;
   localparam int LDS_BIT_DET_FLAG = 11;
   localparam int LDS_BIT_REL_FLAG = 10;

   // ******************************
   // Reset values
   // ******************************
   localparam logic [15:0] LDS_RST_MODE_EN = 16'h0000;
   localparam logic [15:0] LDS_RST_SENSE_CTRL = 16'h0000;
   localparam logic [1:0] LDS_RST_ROUTE = 2'h0;
   localparam logic [1:0] LDS_RST_IRQ_EN = 2'h0;

   // ******************************
   // Timing
   // ******************************
   localparam int LDS_CLK_PERIOD_PS = 25000;
   localparam int LDS_FILT_TIME_NS = 20000;
   localparam int LDS_FILT_CYC =
      (LDS_FILT_TIME_NS * 1000 + LDS_CLK_PERIOD_PS - 1) / LDS_CLK_PERIOD_PS;
   localparam int LDS_CNT_W = 10;
   localparam logic [9:0] LDS_FILT_LAST = 10'(LDS_FILT_CYC - 1);

   // ******************************
   // Chip power state seen from the main state machine
   // ******************************
   typedef enum logic [1:0] {
      LDS_ST_ACTIVE = 2'b00,
      LDS_ST_STANDBY = 2'b01,
      LDS_ST_LOW_POWER = 2'b10,
      LDS_ST_SLEEP = 2'b11
   } lds_chip_state_e;
endpackage : lds_pkg

// File: src/lds_cmp_filter.sv
`timescale 1ns/1ps
module lds_cmp_filter
   import lds_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Raw levels from outside the clock domain
   input wire logic i_det_below,
   input wire logic i_rel_above,
   input wire logic i_fets_off,
   input wire logic i_charger,
   // Control
   input wire logic i_armed,
   // Filtered results
   output logic o_present,
   output logic o_rise,
   output logic o_fall,
   output logic o_charger
);
   // ******************************
   // Two-stage synchronisers
   // ******************************
   logic [3:0] raw;
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   assign raw = {i_charger, i_fets_off, i_rel_above, i_det_below};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= raw[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // ******************************
   // Persistence filter
   // ******************************
   logic [LDS_CNT_W-1:0] cnt_q;
   logic [LDS_CNT_W-1:0] cnt_d;
   logic present_q;
   logic rise_q;
   logic fall_q;
   wire fets_off_s = sync_q[2];
   wire want_set = ~present_q & sync_q[0] & fets_off_s;
   wire want_clr = present_q & sync_q[1] & fets_off_s;
   wire moving = i_armed & (want_set | want_clr);
   wire at_end = moving & (cnt_q == LDS_FILT_LAST);
   // Any break in the new level restarts the count
   assign cnt_d = (moving & ~at_end) ? cnt_q + 10'h001 : 10'h000;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= 10'h000;
         present_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         present_q <= at_end ? ~present_q : present_q;
         rise_q <= at_end & ~present_q;
         fall_q <= at_end & present_q;
      end
   end

   assign o_present = present_q;
   assign o_rise = rise_q;
   assign o_fall = fall_q;
   assign o_charger = sync_q[3];

   // ******************************
   // Checks
   // ******************************
   a_filt_settle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (present_q != $past(present_q)) |-> $past(cnt_q) == LDS_FILT_LAST)
      else $error("load present changed before the filter time");
   a_det_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(present_q) |-> $past(fets_off_s) && $past(sync_q[0]))
      else $error("load detect taken without FETs off and low pin");
   a_rel_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $fell(present_q) |-> $past(fets_off_s) && $past(sync_q[1]))
      else $error("load release taken without FETs off and high pin");
   c_detect: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(present_q));
endmodule : lds_cmp_filter

// File: src/lds_wake_monitor.sv
// What this block does
// - Status 0x27: live bit 15, latched 11/10
// - Detect wakes standby/low-power (bit8), sleep (bit10)
// - Detect only with FETs off, pin low
// - Release clears presence with FETs off, pin high
// - Detect reaches GPIO only when routed
// - Release reaches GPIO only when routed
// - No shutdown while charger input high
// - Presence changes after 20us steady level
// - Control bit0 picks high sink current
`timescale 1ns/1ps
module lds_wake_monitor
   import lds_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Avalon-MM slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Comparators and pack side
   input wire logic i_load_sense_pin_below,
   input wire logic i_load_sense_pin_above,
   input wire logic i_fets_off,
   input wire logic i_charger_sense_pin,
   // Chip state machine
   input wire logic [1:0] i_chip_state,
   output logic o_wake_req,
   output logic o_shutdown_allow,
   // Analog controls
   output logic o_short_check_current_select,
   output logic o_load_sense_power_on,
   // Interrupts
   output logic o_gpio_detect_irq,
   output logic o_gpio_release_irq,
   output logic o_irq
);
   // ******************************
   // Registers
   // ******************************
   logic wait_q;
   logic [31:0] rdata_q;
   logic [15:0] mode_en_q;
   logic [15:0] sense_ctrl_q;
   logic [1:0] route_q;
   logic [1:0] irq_en_q;
   logic det_flag_q;
   logic rel_flag_q;
   logic wake_q;
   logic shut_ok_q;
   logic gpio_det_q;
   logic gpio_rel_q;
   logic irq_q;

   // ******************************
   // Filtered comparator results
   // ******************************
   logic present;
   logic rise;
   logic fall;
   logic charger_s;

   lds_cmp_filter u_filter (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_det_below(i_load_sense_pin_below),
      .i_rel_above(i_load_sense_pin_above),
      .i_fets_off(i_fets_off),
      .i_charger(i_charger_sense_pin),
      .i_armed(sense_ctrl_q[LDS_BIT_POWER_ON]),
      .o_present(present),
      .o_rise(rise),
      .o_fall(fall),
      .o_charger(charger_s)
   );

   // ******************************
   // Bus decode
   // ******************************
   wire [7:0] idx = i_avs_address[9:2];
   wire req = i_avs_read | i_avs_write;
   // One wait cycle per access keeps the read mux off the bus path
   wire wr_go = i_avs_write & ~wait_q;
   wire rd_load = i_avs_read & wait_q;
   wire sel_mode = idx == LDS_IDX_MODE_EN;
   wire sel_ctrl = idx == LDS_IDX_SENSE_CTRL;
   wire sel_route = idx == LDS_IDX_GPIO_ROUTE;
   wire sel_stat = idx == LDS_IDX_STATUS;
   wire sel_istat = idx == LDS_IDX_IRQ_STAT;
   wire sel_iclr = idx == LDS_IDX_IRQ_CLR;
   wire sel_ien = idx == LDS_IDX_IRQ_EN;
   wire clr_det = wr_go & sel_iclr & i_avs_writedata[LDS_BIT_DET_FLAG];
   wire clr_rel = wr_go & sel_iclr & i_avs_writedata[LDS_BIT_REL_FLAG];
   wire [15:0] stat_word = {present, 3'h0, det_flag_q, rel_flag_q, 10'h000};
   wire [15:0] istat_word = {4'h0, det_flag_q, rel_flag_q, 10'h000};
   wire [15:0] ien_word = {4'h0, irq_en_q, 10'h000};
   wire [15:0] rd_word = sel_mode ? mode_en_q :
                         sel_ctrl ? sense_ctrl_q :
                         sel_route ? {14'h0000, route_q} :
                         sel_stat ? stat_word :
                         sel_istat ? istat_word :
                         sel_ien ? ien_word : 16'h0000;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_load) begin
         rdata_q <= {16'h0000, rd_word};
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_en_q <= LDS_RST_MODE_EN;
      end else if (wr_go & sel_mode) begin
         mode_en_q <= i_avs_writedata[15:0];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sense_ctrl_q <= LDS_RST_SENSE_CTRL;
      end else if (wr_go & sel_ctrl) begin
         sense_ctrl_q <= i_avs_writedata[15:0];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         route_q <= LDS_RST_ROUTE;
      end else if (wr_go & sel_route) begin
         route_q <= i_avs_writedata[1:0];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_en_q <= LDS_RST_IRQ_EN;
      end else if (wr_go & sel_ien) begin
         irq_en_q <= i_avs_writedata[LDS_BIT_DET_FLAG:LDS_BIT_REL_FLAG];
      end
   end

   // ******************************
   // Latched flags, wake and outputs
   // ******************************
   wire st_stb_lp = (i_chip_state == LDS_ST_STANDBY) | (i_chip_state == LDS_ST_LOW_POWER);
   wire st_sleep = i_chip_state == LDS_ST_SLEEP;
   wire wake_d = rise & ((st_stb_lp & mode_en_q[LDS_BIT_STB_WAKE]) |
                         (st_sleep & mode_en_q[LDS_BIT_SLP_WAKE]));
   // An event in the clearing cycle wins, so no edge is lost
   wire det_d = rise | (det_flag_q & ~clr_det);
   wire rel_d = fall | (rel_flag_q & ~clr_rel);
   wire irq_d = |({det_d, rel_d} & irq_en_q);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         det_flag_q <= 1'b0;
         rel_flag_q <= 1'b0;
      end else begin
         det_flag_q <= det_d;
         rel_flag_q <= rel_d;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_q <= 1'b0;
         shut_ok_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
         shut_ok_q <= ~charger_s;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         gpio_det_q <= 1'b0;
         gpio_rel_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         gpio_det_q <= det_d & route_q[LDS_BIT_ROUTE_DET];
         gpio_rel_q <= rel_d & route_q[LDS_BIT_ROUTE_REL];
         irq_q <= irq_d;
      end
   end

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_wake_req = wake_q;
   assign o_shutdown_allow = shut_ok_q;
   assign o_short_check_current_select = sense_ctrl_q[LDS_BIT_SHORT_SEL];
   assign o_load_sense_power_on = sense_ctrl_q[LDS_BIT_POWER_ON];
   assign o_gpio_detect_irq = gpio_det_q;
   assign o_gpio_release_irq = gpio_rel_q;
   assign o_irq = irq_q;

   // ******************************
   // Checks
   // ******************************
   wire route_det = route_q[LDS_BIT_ROUTE_DET];
   wire route_rel = route_q[LDS_BIT_ROUTE_REL];
   wire en_stb = mode_en_q[LDS_BIT_STB_WAKE];
   wire en_slp = mode_en_q[LDS_BIT_SLP_WAKE];
   wire rd_stat = i_avs_read & wait_q & sel_stat;

   a_stat_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      rd_stat |=> o_avs_readdata[LDS_BIT_PRESENT] == $past(present) &&
                  o_avs_readdata[LDS_BIT_DET_FLAG] == $past(det_flag_q) && !o_avs_waitrequest)
      else $error("status read returned wrong load bits");
   a_wake_cause: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_wake_req |-> $past(rise) && (($past(st_stb_lp) && $past(en_stb)) ||
                                     ($past(st_sleep) && $past(en_slp))))
      else $error("wake request without enabled detect");
   a_wake_made: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (rise && st_sleep && en_slp) |=> o_wake_req)
      else $error("enabled sleep wake missed");
   a_gpio_route: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_gpio_detect_irq |-> $past(route_det) && $past(det_d))
      else $error("detect reached GPIO without routing");
   a_gpio_rel: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (fall && route_rel) |=> o_gpio_release_irq)
      else $error("routed release not signalled");
   a_no_shutdown: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      charger_s |=> !o_shutdown_allow)
      else $error("shutdown allowed with charger high");
   a_short_sel: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_go && sel_ctrl) |=> o_short_check_current_select == $past(i_avs_writedata[0]))
      else $error("sink current select not written");
   a_flag_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (det_flag_q && !clr_det) |=> det_flag_q)
      else $error("detect flag lost without clear");
   a_flag_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (fall && clr_rel) |=> rel_flag_q)
      else $error("release event lost to a clear");

   a_stat_rel: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      rd_stat |=> o_avs_readdata[LDS_BIT_REL_FLAG] == $past(rel_flag_q))
      else $error("status read returned wrong release flag");
   a_wait_ends: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_back: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_stb_wake: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (rise && st_stb_lp && en_stb) |=> o_wake_req)
      else $error("enabled standby wake missed");
   a_wake_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_wake_req |=> !o_wake_req)
      else $error("wake request longer than one cycle");
   a_wake_none: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !rise |=> !o_wake_req)
      else $error("wake request without a detect edge");

   a_det_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      rise |=> det_flag_q)
      else $error("detect edge did not latch its flag");
   a_det_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (clr_det && !rise) |=> !det_flag_q)
      else $error("detect flag survived its clear");
   a_rel_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      fall |=> rel_flag_q)
      else $error("release edge did not latch its flag");
   a_rel_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (rel_flag_q && !clr_rel) |=> rel_flag_q)
      else $error("release flag lost without clear");

   // Enable writes land one edge after the flags, hence the stable guard
   a_irq_level: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $stable(irq_en_q) |-> o_irq == ((det_flag_q && irq_en_q[1]) ||
                                      (rel_flag_q && irq_en_q[0])))
      else $error("interrupt line disagrees with enabled flags");
   a_gpio_det_made: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (rise && route_det) |=> o_gpio_detect_irq)
      else $error("routed detect not signalled");
   a_gpio_rel_route: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_gpio_release_irq |-> $past(route_rel))
      else $error("release reached GPIO without routing");
   a_shut_free: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !charger_s |=> o_shutdown_allow)
      else $error("shutdown blocked with charger low");
   a_armed_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $changed(present) |-> $past(o_load_sense_power_on))
      else $error("load present changed with sensing off");
   a_short_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !(wr_go && sel_ctrl) |=> $stable(o_short_check_current_select))
      else $error("sink current select changed without a write");

   c_wake: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) o_wake_req);
   c_release: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) o_gpio_release_irq);
   c_irq: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_irq));
   c_stat: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) rd_stat);
endmodule : lds_wake_monitor

// File: verif/lds_pack_model.sv
`timescale 1ns/1ps
// ********
// Pack terminal: load and charger
// ********
module lds_pack_model (
   // Far side conditions
   input wire logic i_load,
   input wire logic i_charger,
   input wire logic i_fets_off,
   input wire logic i_sensing,
   // Comparator and charger pins
   output logic o_below,
   output logic o_above,
   output logic o_chg
);
   // Load pulls the pin down only while sink current flows
   assign o_below = i_load & i_sensing;
   assign o_above = i_sensing & ~i_load;
   // Shared wiring: pin high with charger or FETs on
   assign o_chg = i_charger | ~i_fets_off;
endmodule : lds_pack_model

// File: verif/lds_wake_monitor_tb.sv
`timescale 1ns/1ps
module lds_wake_monitor_tb;
   import lds_pkg::*;
   // ********
   // Stimulus and observation
   // ********
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] adr = 10'h000;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic load_on = 1'b0;
   logic chg_on = 1'b0;
   logic fets_off = 1'b1;
   logic [1:0] st = LDS_ST_ACTIVE;
   logic below, above, chg, wake, shut, shrt, pwr, gdet, grel, irq;
   logic [31:0] rv;
   int miscompares = 0;
   int total_checks = 0;
   int wakes = 0;
   int n;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
   lds_pack_model pack (.i_load(load_on), .i_charger(chg_on), .i_fets_off(fets_off),
      .i_sensing(pwr), .o_below(below), .o_above(above), .o_chg(chg));
   lds_wake_monitor uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_load_sense_pin_below(below),
      .i_load_sense_pin_above(above), .i_fets_off(fets_off), .i_charger_sense_pin(chg),
      .i_chip_state(st), .o_wake_req(wake), .o_shutdown_allow(shut),
      .o_short_check_current_select(shrt), .o_load_sense_power_on(pwr),
      .o_gpio_detect_irq(gdet), .o_gpio_release_irq(grel), .o_irq(irq));
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Hold request until waitrequest seen low, release on that edge
   task bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
      int k;
      @(posedge clk);
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      wr_en <= w;
      rd_en <= ~w;
      k = 0;
      // Answer and read data count only at the rising edge
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      if (wreq !== 1'b0) begin
         miscompares++;
         $display("MISMATCH t=%0t bus access timed out", $time);
         finish_test;
      end else begin
         rv = rdat;
         wr_en <= 1'b0;
         rd_en <= 1'b0;
      end
   endtask : bus
   task rd_chk(input logic [7:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000);
      check(rv, {16'h0000, exp});
   endtask : rd_chk
   task cyc(input int c);
      repeat (c) @(posedge clk);
   endtask : cyc
   initial begin
      cyc(15000);
      miscompares++;
      finish_test;
   end
   initial begin
      cyc(20);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      check(shut, 1'b1);
      rd_chk(LDS_IDX_MODE_EN, LDS_RST_MODE_EN);
      rd_chk(LDS_IDX_SENSE_CTRL, LDS_RST_SENSE_CTRL);
      rd_chk(LDS_IDX_STATUS, 16'h0000);
      rd_chk(8'h05, 16'h0000);
      bus(1'b1, LDS_IDX_MODE_EN, 16'h0100);
      bus(1'b1, LDS_IDX_SENSE_CTRL, 16'h0009);
      bus(1'b1, LDS_IDX_STATUS, 16'hffff);
      rd_chk(LDS_IDX_MODE_EN, 16'h0100);
      rd_chk(LDS_IDX_SENSE_CTRL, 16'h0009);
      rd_chk(LDS_IDX_STATUS, 16'h0000);
      check(shrt, 1'b1);
      check(pwr, 1'b1);
      bus(1'b1, LDS_IDX_GPIO_ROUTE, 16'h0003);
      bus(1'b1, LDS_IDX_IRQ_EN, 16'h0c00);
      // ********
      // Short load pulse must be filtered out
      // ********
      load_on <= 1'b1;
      cyc(400);
      load_on <= 1'b0;
      cyc(900);
      check(gdet, 1'b0);
      // Load with FETs on is never a detection
      fets_off <= 1'b0;
      load_on <= 1'b1;
      st <= LDS_ST_STANDBY;
      cyc(900);
      check(gdet, 1'b0);
      check(wakes, 0);
      check(shut, 1'b0);
      fets_off <= 1'b1;
      repeat (790) @(negedge clk);
      check(gdet, 1'b0);
      for (n = 0; n < 100 && gdet !== 1'b1; n++) @(negedge clk);
      // Wake pulse is counted one edge after the flag shows
      @(negedge clk);
      check(gdet, 1'b1);
      check(wakes, 1);
      check(irq, 1'b1);
      check(grel, 1'b0);
      rd_chk(LDS_IDX_STATUS, 16'h8800);
      st <= LDS_ST_ACTIVE;
      // Mask detect, release stays enabled
      bus(1'b1, LDS_IDX_IRQ_EN, 16'h0400);
      repeat (2) @(negedge clk);
      check(irq, 1'b0);
      // FETs stay off while load shows present
      @(posedge clk);
      load_on <= 1'b0;
      for (n = 0; n < 1000 && grel !== 1'b1; n++) @(negedge clk);
      check(grel, 1'b1);
      check(irq, 1'b1);
      check(wakes, 1);
      rd_chk(LDS_IDX_STATUS, 16'h0c00);
      bus(1'b1, LDS_IDX_IRQ_CLR, 16'h0c00);
      repeat (2) @(negedge clk);
      check(irq, 1'b0);
      check(gdet, 1'b0);
      rd_chk(LDS_IDX_STATUS, 16'h0000);
      rd_chk(LDS_IDX_IRQ_STAT, 16'h0000);
      // ********
      // Sleep wake needs its own enable
      // ********
      st <= LDS_ST_SLEEP;
      load_on <= 1'b1;
      cyc(900);
      check(gdet, 1'b1);
      check(wakes, 1);
      load_on <= 1'b0;
      cyc(900);
      bus(1'b1, LDS_IDX_MODE_EN, 16'h0400);
      load_on <= 1'b1;
      cyc(900);
      check(wakes, 2);
      chg_on <= 1'b1;
      repeat (5) @(negedge clk);
      check(shut, 1'b0);
      finish_test;
   end
endmodule : lds_wake_monitor_tb
